// ===== rtl/mmx_map.vh
// Constants for the move/multiply execution block
// Assumes inclusion by the single design file of this block
`ifndef MMX_MAP_VH
`define MMX_MAP_VH
`define MMX_OP7_STORE 7'h37
`define MMX_OP8_MULLIT 8'h0D
`define MMX_OP7_MULFILE 7'h01
`define MMX_OPC_HI 15
`define MMX_OPC7_LO 9
`define MMX_OPC8_LO 8
`define MMX_BANK_BIT 8
`define MMX_FADDR_HI 7
`define MMX_FADDR_LO 0
`define MMX_PHI_HI 15
`define MMX_PHI_LO 8
`define MMX_PLO_HI 7
`define MMX_PLO_LO 0
`define MMX_ZERO4 4'h0
`define MMX_IDX_LIMIT 8'h5F
`define MMX_ACCESS_SPLIT 8'h60
`define MMX_ACCESS_HI_BANK 4'hF
`define MMX_ACCESS_LO_BANK 4'h0
`define MMX_PH_DECODE 2'h0
`define MMX_PH_READ 2'h1
`define MMX_PH_PROCESS 2'h2
`define MMX_PH_WRITE 2'h3
`define MMX_ZERO8 8'h00
`define MMX_ZERO12 12'h000
`define MMX_ZERO16 16'h0000
`endif

// ===== rtl/mmx_move_multiply_exec.v
// Execution of store-accumulator and the two unsigned multiplies of a small 8-bit core
// Assumes the fetch unit holds instr_i stable for a whole four-phase instruction cycle
// and that file memory answers a read address in the same cycle (combinational read data).
// Operation
// - Store accumulator to addressed file, flags untouched
// - Eight-bit file address spans whole bank
// - Bank bit clear: access bank; set: selector
// - Extended set, access, addr<=5Fh: indexed offset
// - Literal multiply gives unsigned 16-bit product
// - High byte to product_high, accumulator kept
// - File multiply, both operands left unchanged
// - Multiplies never touch any status flag
`timescale 1ns/10ps
`include "mmx_map.vh"
module mmx_move_multiply_exec (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // Instruction and core state
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [7:0] accum_i,
  input wire [3:0] bank_selector_i,
  input wire ext_set_en_i,
  input wire [11:0] index_base_i,
  // File memory
  input wire [7:0] file_rdata_i,
  output reg [11:0] file_addr_o,
  output reg file_rd_o,
  output reg [7:0] file_wdata_o,
  output reg file_we_o,
  // Product pair and phase
  output reg [7:0] product_high_o,
  output reg [7:0] product_low_o,
  output reg product_we_o,
  output reg [1:0] phase_o,
  output reg busy_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;

  localparam OP_NONE = 2'h0;
  localparam OP_STORE = 2'h1;
  localparam OP_MULLIT = 2'h2;
  localparam OP_MULFILE = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] phase_nxt;
  reg [1:0] op_r;
  reg [1:0] op_nxt;
  reg [7:0] operand_r;
  reg [7:0] operand_nxt;
  reg [11:0] addr_r;
  reg [11:0] addr_nxt;
  reg [15:0] prod_r;
  reg [15:0] prod_nxt;
  reg [7:0] acc_r;
  reg [7:0] acc_nxt;
  reg in_write_nxt;
  reg file_rd_nxt;
  reg file_we_nxt;
  reg product_we_nxt;

  // Full 12-bit data address of a byte-oriented operand
  function [11:0] file_address;
    input [7:0] f;
    input a;
    input ext;
    input [3:0] bsel;
    input [11:0] base;
    begin
      if (a) begin
        file_address = {bsel, f};
      end else if (ext && (f <= `MMX_IDX_LIMIT)) begin
        file_address = base + {`MMX_ZERO4, f};
      end else if (f >= `MMX_ACCESS_SPLIT) begin
        file_address = {`MMX_ACCESS_HI_BANK, f};
      end else begin
        file_address = {`MMX_ACCESS_LO_BANK, f};
      end
    end
  endfunction

  // Decode of the opcode class
  function [1:0] op_class;
    input [15:0] ins;
    begin
      if (ins[`MMX_OPC_HI:`MMX_OPC7_LO] == `MMX_OP7_STORE) begin
        op_class = OP_STORE;
      end else if (ins[`MMX_OPC_HI:`MMX_OPC8_LO] == `MMX_OP8_MULLIT) begin
        op_class = OP_MULLIT;
      end else if (ins[`MMX_OPC_HI:`MMX_OPC7_LO] == `MMX_OP7_MULFILE) begin
        op_class = OP_MULFILE;
      end else begin
        op_class = OP_NONE;
      end
    end
  endfunction

  // Operand fields and decode of the word on the instruction bus
  wire [7:0] fld_addr;
  wire fld_bank;
  wire [1:0] dec_class;
  wire dec_hit;
  wire [11:0] dec_addr;
  assign fld_addr = instr_i[`MMX_FADDR_HI:`MMX_FADDR_LO];
  assign fld_bank = instr_i[`MMX_BANK_BIT];
  assign dec_class = op_class(instr_i);
  assign dec_hit = (dec_class != OP_NONE);
  assign dec_addr = file_address(fld_addr, fld_bank, ext_set_en_i, bank_selector_i, index_base_i);

  always @* begin
    state_nxt = state_r;
    phase_nxt = phase_o;
    op_nxt = op_r;
    operand_nxt = operand_r;
    addr_nxt = addr_r;
    prod_nxt = prod_r;
    acc_nxt = acc_r;
    case (state_r)
      ST_IDLE: begin
        phase_nxt = `MMX_PH_DECODE;
        if (instr_valid_i && dec_hit) begin
          // Q1: decode and latch address
          op_nxt = dec_class;
          addr_nxt = dec_addr;
          acc_nxt = accum_i;
          state_nxt = ST_RUN;
          phase_nxt = `MMX_PH_READ;
        end
      end
      ST_RUN: begin
        case (phase_o)
          `MMX_PH_READ: begin
            // Q2: read literal or file operand
            if (op_r == OP_MULFILE) begin
              operand_nxt = file_rdata_i;
            end else begin
              operand_nxt = fld_addr;
            end
            phase_nxt = `MMX_PH_PROCESS;
          end
          `MMX_PH_PROCESS: begin
            // Q3: unsigned product; no flag output exists, so zero is never flagged
            prod_nxt = {`MMX_ZERO8, acc_r} * {`MMX_ZERO8, operand_r};
            phase_nxt = `MMX_PH_WRITE;
          end
          default: begin
            state_nxt = ST_IDLE;
            phase_nxt = `MMX_PH_DECODE;
            op_nxt = OP_NONE;
          end
        endcase
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Strobes are worked out one cycle ahead so that every port leaves a flip-flop
  always @* begin
    in_write_nxt = (state_nxt == ST_RUN) && (phase_nxt == `MMX_PH_WRITE);
    file_rd_nxt = (state_nxt == ST_RUN) && (phase_nxt == `MMX_PH_READ) && (op_nxt == OP_MULFILE);
    file_we_nxt = in_write_nxt && (op_nxt == OP_STORE);
    product_we_nxt = in_write_nxt && ((op_nxt == OP_MULLIT) || (op_nxt == OP_MULFILE));
  end

  // Sequencer state
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      phase_o <= `MMX_PH_DECODE;
      op_r <= OP_NONE;
      operand_r <= `MMX_ZERO8;
      addr_r <= `MMX_ZERO12;
      prod_r <= `MMX_ZERO16;
      acc_r <= `MMX_ZERO8;
      busy_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_o <= phase_nxt;
      op_r <= op_nxt;
      operand_r <= operand_nxt;
      addr_r <= addr_nxt;
      prod_r <= prod_nxt;
      acc_r <= acc_nxt;
      busy_o <= (state_nxt == ST_RUN);
    end
  end

  // File memory port
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      file_addr_o <= `MMX_ZERO12;
      file_rd_o <= 1'b0;
      file_wdata_o <= `MMX_ZERO8;
      file_we_o <= 1'b0;
    end else begin
      // Address is presented during Q2 so the file read lands in that phase
      file_addr_o <= addr_nxt;
      file_rd_o <= file_rd_nxt;
      // The accumulator is only read, never written, so it stays intact
      file_wdata_o <= acc_nxt;
      file_we_o <= file_we_nxt;
    end
  end

  // Product pair holds between multiplies; no zero or carry flag is derived from it
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      product_high_o <= `MMX_ZERO8;
      product_low_o <= `MMX_ZERO8;
      product_we_o <= 1'b0;
    end else begin
      product_we_o <= product_we_nxt;
      if (product_we_nxt) begin
        product_high_o <= prod_nxt[`MMX_PHI_HI:`MMX_PHI_LO];
        product_low_o <= prod_nxt[`MMX_PLO_HI:`MMX_PLO_LO];
      end
    end
  end

endmodule

// ===== verification/mmx_exec_sva.sv
// Port checks for the exec block
// Bound to the design top
`timescale 1ns/10ps
module mmx_exec_sva (
  // Clock and reset
  input logic core_clk_i,
  input logic reset_n_i,
  // Instruction and core state
  input logic instr_valid_i,
  input logic [15:0] instr_i,
  input logic [7:0] accum_i,
  input logic [3:0] bank_selector_i,
  input logic ext_set_en_i,
  input logic [11:0] index_base_i,
  // File memory, product pair and phase
  input logic [11:0] file_addr_o,
  input logic file_rd_o,
  input logic [7:0] file_wdata_o,
  input logic file_we_o,
  input logic [7:0] product_high_o,
  input logic [7:0] product_low_o,
  input logic product_we_o,
  input logic [1:0] phase_o,
  input logic busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire [7:0] f = instr_i[7:0];
  wire go = instr_valid_i && !phase_o;
  wire st = go && instr_i[15:9] == 7'h37;
  wire ml = go && instr_i[15:8] == 8'h0D;
  wire mf = go && instr_i[15:9] == 7'h01;
  wire sf = st || mf;
  wire abk = sf && !instr_i[8];
  wire idx = abk && ext_set_en_i && f <= 8'h5F;
  wire [15:0] p = {product_high_o, product_low_o};
  sequence s_q; phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 &phase_o ##1 !phase_o; endsequence
  property p_q; sf || ml |=> s_q; endproperty
  a_q: assert property (p_q) else $error("phase");
  property p_st; st |=> ##2 file_we_o && file_wdata_o == $past(accum_i, 3); endproperty
  a_st: assert property (p_st) else $error("store");
  property p_ml; ml |=> ##2 product_we_o && p == $past(accum_i, 3) * $past(f, 3); endproperty
  a_ml: assert property (p_ml) else $error("literal");
  property p_mf; sf && !st |=> ##2 product_we_o; endproperty
  a_mf: assert property (p_mf) else $error("file");
  property p_bk; sf && instr_i[8] |=> file_addr_o == {$past(bank_selector_i), $past(f)}; endproperty
  a_bk: assert property (p_bk) else $error("bank");
  property p_ix; idx |=> file_addr_o == $past(index_base_i) + $past(f); endproperty
  a_ix: assert property (p_ix) else $error("indexed");
  property p_ac; abk && !idx |=> file_addr_o == {(($past(f) >= 8'h60) ? 4'hF : 4'h0), $past(f)}; endproperty
  a_ac: assert property (p_ac) else $error("access");
  property p_rd; mf |=> file_rd_o ##1 !file_rd_o; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_kp; $changed(p) |-> product_we_o; endproperty
  a_kp: assert property (p_kp) else $error("product");
  property p_we; file_we_o |-> &phase_o; endproperty
  a_we: assert property (p_we) else $error("strobe");
  property p_bz; busy_o == |phase_o; endproperty
  a_bz: assert property (p_bz) else $error("busy");
endmodule
bind mmx_move_multiply_exec mmx_exec_sva i_sva (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .instr_valid_i(instr_valid_i),
  .instr_i(instr_i),
  .accum_i(accum_i),
  .bank_selector_i(bank_selector_i),
  .ext_set_en_i(ext_set_en_i),
  .index_base_i(index_base_i),
  .file_addr_o(file_addr_o),
  .file_rd_o(file_rd_o),
  .file_wdata_o(file_wdata_o),
  .file_we_o(file_we_o),
  .product_high_o(product_high_o),
  .product_low_o(product_low_o),
  .product_we_o(product_we_o),
  .phase_o(phase_o),
  .busy_o(busy_o)
);

// ===== verification/move_multiply_exec_tb_top.sv
// Self-checking exec bench
// Drives all design ports itself
`timescale 1ns/10ps
module move_multiply_exec_tb_top;
  reg core_clk_i = 1'b0, reset_n_i = 1'b0, instr_valid_i = 1'b0, ext_set_en_i = 1'b1;
  reg [15:0] instr_i = '0;
  reg [7:0] accum_i = '0, file_rdata_i = '0;
  reg [3:0] bank_selector_i = 4'h3;
  // Base near the top so the indexed sum wraps
  reg [11:0] index_base_i = 12'hFF1;
  wire [11:0] file_addr_o;
  wire [7:0] file_wdata_o, product_high_o, product_low_o;
  wire [1:0] phase_o;
  wire file_rd_o, file_we_o, product_we_o, busy_o;
  integer failures = 0, checked = 0, cycles = 0;
  mmx_move_multiply_exec i_mmx_move_multiply_exec (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .accum_i(accum_i),
    .bank_selector_i(bank_selector_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .file_rdata_i(file_rdata_i),
    .file_addr_o(file_addr_o),
    .file_rd_o(file_rd_o),
    .file_wdata_o(file_wdata_o),
    .file_we_o(file_we_o),
    .product_high_o(product_high_o),
    .product_low_o(product_low_o),
    .product_we_o(product_we_o),
    .phase_o(phase_o),
    .busy_o(busy_o)
  );
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (++cycles > 300) begin
    failures++;
    tally_and_finish;
  end
  task chk(string w, logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask
  // File data stands only in the Q2 cycle, so a read in any other phase gets its inverse
  task run(logic [15:0] i, logic [7:0] a, r);
    @(posedge core_clk_i) #1 {instr_i, accum_i, file_rdata_i, instr_valid_i} = {i, a, ~r, 1'b1};
    @(posedge core_clk_i) #1 {instr_valid_i, file_rdata_i} = {1'b0, r};
    chk("rd", file_rd_o, {15'h0000, i[15:9] == 7'h01});
    @(posedge core_clk_i) #1 file_rdata_i = ~r;
    @(posedge core_clk_i) #1;
  endtask
  task t_mul;
    run(16'h0DC4, 8'hE2, 8'h00);
    chk("prod", {product_high_o, product_low_o}, 16'hAD08);
    chk("pwe", product_we_o, 16'h0001);
    run(16'h03FF, 8'hC4, 8'hB5);
    chk("prod", {product_high_o, product_low_o}, 16'h8A94);
    chk("addr", file_addr_o, 16'h03FF);
    run(16'h0DFF, 8'hFF, 8'h00);
    chk("prod", {product_high_o, product_low_o}, 16'hFE01);
    run(16'h0D00, 8'h9C, 8'h00);
    chk("prod", {product_high_o, product_low_o}, 16'h0000);
    run(16'h0220, 8'h10, 8'h0A);
    chk("prod", {product_high_o, product_low_o}, 16'h00A0);
    chk("addr", file_addr_o, 16'h0011);
    $display("mul done");
  endtask
  task t_store;
    run(16'h6E5F, 8'h4F, 8'h00);
    chk("addr", file_addr_o, 16'h0050);
    chk("data", file_wdata_o, 16'h004F);
    chk("we", file_we_o, 16'h0001);
    run(16'h6E80, 8'h11, 8'h00);
    chk("addr", file_addr_o, 16'h0F80);
    ext_set_en_i = 1'b0;
    run(16'h6E20, 8'h22, 8'h00);
    chk("addr", file_addr_o, 16'h0020);
    run(16'h6F12, 8'h33, 8'h00);
    chk("addr", file_addr_o, 16'h0312);
    chk("data", file_wdata_o, 16'h0033);
    chk("prod", {product_high_o, product_low_o}, 16'h00A0);
    $display("store done");
  endtask
  // A second word offered while busy must be ignored
  task t_busy;
    @(posedge core_clk_i) #1 {instr_i, accum_i, instr_valid_i} = {16'h0D03, 8'h05, 1'b1};
    repeat (2) @(posedge core_clk_i) #1;
    instr_i = 16'h6E10;
    @(posedge core_clk_i) #1;
    chk("prod", {product_high_o, product_low_o}, 16'h000F);
    @(posedge core_clk_i) #1 instr_valid_i = 1'b0;
    chk("busy", busy_o, 16'h0000);
    chk("we", file_we_o, 16'h0000);
    $display("busy done");
  endtask
  task t_refuse;
    run(16'h0E55, 8'h44, 8'h00);
    chk("busy", busy_o, 16'h0000);
    chk("prod", {product_high_o, product_low_o}, 16'h000F);
    $display("refuse done");
  endtask
  task tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    t_mul;
    t_store;
    t_busy;
    t_refuse;
    tally_and_finish;
  end
endmodule
